// file: bench/qnp_board.sv
// board model resolving each port pin from all drivers and pull-ups
`timescale 1ns/100ps
module qnp_board (
	input wire logic i_ref_clk,
	input wire logic [15:0] i_drive,
	input wire logic [15:0] i_drive_oe,
	input wire logic [15:0] i_pullup_en,
	input wire logic [15:0] i_ext_val,
	input wire logic [15:0] i_ext_oe,
	output logic [15:0] o_level
);
	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	logic [15:0] float_q; // pattern for lines nobody holds
	initial float_q = 16'h5A5A;
	// floating lines change every cycle, never a stale value
	always @(posedge i_ref_clk) begin
		float_q <= ~float_q;
	end
	// device drive first, then board drive, then pull-up, else float
	always_comb begin
		for (int n = 0; n < 16; n++) begin
			if (i_drive_oe[n]) o_level[n] = i_drive[n];
			else if (i_ext_oe[n]) o_level[n] = i_ext_val[n];
			else if (i_pullup_en[n]) o_level[n] = 1'b1;
			else o_level[n] = float_q[n];
		end
	end
endmodule

// file: bench/qnp_port_tb.sv
// self-checking bench for the quad nibble io port
`timescale 1ns/100ps
module qnp_port_tb;
	import qnp_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 0, rst = 1;
	logic [13:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, arvalid = 0;
	logic [31:0] wdata = 0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [15:0] pin, drv, oe, pu, ext_val = 16'h1234, ext_oe = 16'h7FFF;
	logic [31:0] d;
	int fails = 0, num_checks = 0, cyc = 0;
	always #10 clk = ~clk;
	// pin 13 open drain per bit, group 1 open drain, pin 15 dedicated
	qnp_port #(.OPEN_DRAIN(16'h2010), .DEDICATED(4'h8)) dut (.i_ref_clk(clk),
		.i_reset(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(1'b1), .i_pin(pin), .o_pin(drv),
		.o_pin_oe(oe), .o_pullup_en(pu));
	qnp_board board (.i_ref_clk(clk), .i_drive(drv), .i_drive_oe(oe),
		.i_pullup_en(pu), .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(pin));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] idx, input logic [3:0] v);
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {28'h0, v};
		awvalid <= 1;
		wvalid <= 1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		r = bresp;
	endtask
	task automatic rd(input logic [11:0] idx);
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
	endtask
	// let the pins follow a register write
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		settle;
		chk("oe", oe, 16'h8000);
		chk("pullup", pu, 16'h7FFF);
		rd(QNP_IDX_DIRECTION);
		chk("dir", d, 0);
		rd(QNP_IDX_PULLUP);
		chk("pupreg", d, 0);
		$display("reset done");
	endtask
	task automatic t_input;
		wr(QNP_IDX_GROUP0_DATA, 4'hA);
		settle;
		chk("oe0", oe[3:0], 0);
		rd(QNP_IDX_GROUP0_DATA);
		chk("in0", d, 4);
		$display("input done");
	endtask
	task automatic t_output;
		ext_oe <= 16'h70F0;
		wr(QNP_IDX_DIRECTION, 4'h5);
		settle;
		chk("oe0", oe[3:0], 4'hF);
		chk("pin0", drv[3:0], 4'hA);
		rd(QNP_IDX_GROUP0_DATA);
		chk("out0", d, 4'hA);
		$display("output done");
	endtask
	task automatic t_open_drain;
		ext_oe <= 16'h7000;
		wr(QNP_IDX_GROUP1_DATA, 4'h6);
		wr(QNP_IDX_DIRECTION, 4'h7);
		settle;
		chk("oe1", oe[7:4], 4'h9);
		chk("low1", drv[7:4] & 4'h9, 0);
		rd(QNP_IDX_GROUP1_DATA);
		chk("rd1", d, 4'h6);
		$display("open drain done");
	endtask
	task automatic t_dedicated;
		ext_oe <= 0;
		wr(QNP_IDX_GROUP3_DATA, 4'hA);
		settle;
		chk("ded", {oe[15:12], drv[15]}, 5'b10001);
		wr(QNP_IDX_DIRECTION, 4'hF);
		settle;
		chk("oe3", oe[15:12], 4'b1101);
		$display("dedicated done");
	endtask
	task automatic t_pullup;
		wr(QNP_IDX_PULLUP, 4'h2);
		settle;
		chk("pu1", pu, 16'h7F0F);
		wr(QNP_IDX_PULLUP, 4'hF);
		rd(QNP_IDX_PULLUP);
		chk("pupreg", d, 4'hF);
		chk("pu_off", pu, 0);
		rd(QNP_IDX_DIRECTION);
		chk("dir", d, 4'hF);
		$display("pullup done");
	endtask
	task automatic t_unmapped;
		wr(12'hF64, 4'h5);
		chk("bresp", r, QNP_RESP_SLVERR);
		rd(12'hF64);
		chk("rresp", r, QNP_RESP_SLVERR);
		chk("rdata", d, 32'h00000000);
		// pull-ups back on so the released open-drain pin reads high
		wr(QNP_IDX_PULLUP, 4'h0);
		rd(QNP_IDX_GROUP3_DATA);
		chk("g3resp", r, QNP_RESP_OKAY);
		chk("g3", d, 32'h0000000A);
		chk("pu_on", pu, 16'h7FFF);
		$display("unmapped done");
	endtask
	// ----------------------------------------
	// run
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		t_reset();
		t_input();
		t_output();
		t_open_drain();
		t_dedicated();
		t_pullup();
		t_unmapped();
		conclude();
	end
endmodule

// file: design/qnp_pkg.sv
// package of constants and types for the quad nibble io port
package qnp_pkg;
	// ----------------------------------------
	// register index constants
	// ----------------------------------------
	localparam logic [11:0] QNP_IDX_GROUP0_DATA = 12'hF60; // group 0 data index
	localparam logic [11:0] QNP_IDX_GROUP1_DATA = 12'hF61; // group 1 data index
	localparam logic [11:0] QNP_IDX_GROUP2_DATA = 12'hF62; // group 2 data index
	localparam logic [11:0] QNP_IDX_GROUP3_DATA = 12'hF63; // group 3 data index
	localparam logic [11:0] QNP_IDX_DIRECTION = 12'hF7D; // direction index
	localparam logic [11:0] QNP_IDX_PULLUP = 12'hF7E; // pull-up disable index
	// ----------------------------------------
	// layout and reset values
	// ----------------------------------------
	localparam int QNP_GROUPS = 4; // number of groups
	localparam int QNP_GROUP_BITS = 4; // bits per group
	localparam int QNP_PINS = 16; // total pins
	localparam int QNP_ADDR_W = 14; // byte address width
	localparam logic [3:0] QNP_DIR_RESET = 4'h0; // all groups input
	localparam logic [3:0] QNP_PUP_RESET = 4'h0; // all pull-ups on, dedicated bits excepted
	localparam logic [15:0] QNP_DATA_RESET = 16'h0000; // data undefined, zero chosen
	localparam logic [1:0] QNP_RESP_OKAY = 2'h0; // axi okay
	localparam logic [1:0] QNP_RESP_SLVERR = 2'h2; // axi slave error
	// ----------------------------------------
	// slave state encoding
	// ----------------------------------------
	typedef enum logic [1:0] {
		QNP_ST_IDLE = 2'b01, // waiting for request
		QNP_ST_RESP = 2'b10 // answer pending
	} qnp_state_t;
endpackage

// file: design/qnp_port.sv
// quad nibble io port: sixteen bidirectional pins behind an axi4-lite slave
// Operation
// R01 - sixteen pins, four groups, consecutive data registers
// R02 - four-bit readable direction register, bit per group
// R03 - direction zero: group pins undriven inputs
// R04 - direction one: pins drive data register
// R05 - data one drives high, zero low
// R06 - reset clears all direction bits
// R07 - pull-up bit per group, zero enables
// R08 - reset clears all pull-up bits
// R09 - data writes stored in input mode
// R10 - input mode read returns pin level
// R11 - output mode read returns pin level
// R12 - open-drain option per group or bit
// R13 - group three bits optionally dedicated outputs
// R14 - dedicated outputs ignore direction bit
// R15 - dedicated outputs never pulled up
// R16 - open-drain released unpulled pin reads undefined
// R17 - open-drain one releases, zero drives low
// R18 - data registers unspecified after reset
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module qnp_port
	import qnp_pkg::*;
#(
	parameter logic [15:0] OPEN_DRAIN = 16'h0000, // open-drain option, per pin in groups 2 and 3, bit 0 of the group for groups 0 and 1
	parameter logic [3:0] DEDICATED = 4'h0 // group three dedicated output bits
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [QNP_ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [QNP_ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [QNP_PINS-1:0] i_pin,
	output logic [QNP_PINS-1:0] o_pin,
	output logic [QNP_PINS-1:0] o_pin_oe,
	output logic [QNP_PINS-1:0] o_pullup_en
);
	// ----------------------------------------
	// option masks
	// ----------------------------------------
	// groups 0 and 1 take the option from bit 0 of the group
	localparam logic [15:0] OD_EFF = {OPEN_DRAIN[15:8], {4{OPEN_DRAIN[4]}},
		{4{OPEN_DRAIN[0]}}}; // [R12]
	localparam logic [15:0] DED_MASK = {DEDICATED, 12'h000}; // [R13]

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [3:0] dir_q; // group direction bits
	logic [3:0] pup_q; // group pull-up disable bits
	logic [15:0] data_q; // port data registers
	qnp_state_t wst_q; // write channel state
	qnp_state_t rst_q; // read channel state
	logic aw_got_q; // write address taken
	logic w_got_q; // write data taken
	logic [QNP_ADDR_W-1:0] awaddr_q; // held write address
	logic [31:0] wdata_q; // held write data
	logic wstrb0_q; // held low byte strobe

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// map a byte address to a register select, bit 6 means unmapped
	function automatic logic [6:0] qnp_decode(input logic [QNP_ADDR_W-1:0] a);
		logic [11:0] idx;
		logic [6:0] sel;
		idx = a[QNP_ADDR_W-1:2];
		sel = 7'h00;
		if (a[1:0] != 2'h0) begin
			sel = 7'h40;
		end else if (idx == QNP_IDX_GROUP0_DATA) begin
			sel = 7'h01; // [R01]
		end else if (idx == QNP_IDX_GROUP1_DATA) begin
			sel = 7'h02;
		end else if (idx == QNP_IDX_GROUP2_DATA) begin
			sel = 7'h04;
		end else if (idx == QNP_IDX_GROUP3_DATA) begin
			sel = 7'h08;
		end else if (idx == QNP_IDX_DIRECTION) begin
			sel = 7'h10;
		end else if (idx == QNP_IDX_PULLUP) begin
			sel = 7'h20;
		end else begin
			sel = 7'h40;
		end
		return sel;
	endfunction

	// ----------------------------------------
	// pin drive logic
	// ----------------------------------------
	logic [15:0] dir_pin; // direction fanned out per pin
	logic [15:0] pup_pin; // pull-up disable per pin
	logic [15:0] out_mode; // pin in output mode
	logic [15:0] oe_next; // next output enable
	logic [15:0] val_next; // next output value
	logic [15:0] pull_next; // next pull-up enable

	genvar g;
	generate
		for (g = 0; g < QNP_PINS; g++) begin : g_pin
			assign dir_pin[g] = dir_q[g / QNP_GROUP_BITS];
			assign pup_pin[g] = pup_q[g / QNP_GROUP_BITS];
			// dedicated bits output regardless of direction
			assign out_mode[g] = dir_pin[g] | DED_MASK[g]; // [R03] [R04] [R14]
			// open-drain releases on one, complementary drives either value in output mode
			assign oe_next[g] = out_mode[g] & ~(OD_EFF[g] & data_q[g]); // [R17]
			assign val_next[g] = data_q[g]; // [R05]
			// pull-up on when bit is zero, never on dedicated bits
			assign pull_next[g] = ~pup_pin[g] & ~DED_MASK[g]; // [R07] [R15]
		end
	endgenerate

	// register pin outputs
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_pin <= 16'h0000;
			o_pin_oe <= 16'h0000;
			o_pullup_en <= ~DED_MASK; // pulled up, dedicated bits never [R08] [R15]
		end else begin
			o_pin <= val_next;
			o_pin_oe <= oe_next;
			o_pullup_en <= pull_next;
		end
	end

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	logic aw_take; // write address handshake
	logic w_take; // write data handshake
	logic do_write; // both halves present
	logic [QNP_ADDR_W-1:0] wa_eff; // effective write address
	logic [31:0] wd_eff; // effective write data
	logic ws_eff; // effective low strobe
	logic [6:0] wsel; // write select

	assign aw_take = i_awvalid & o_awready;
	assign w_take = i_wvalid & o_wready;
	assign wa_eff = aw_got_q ? awaddr_q : i_awaddr;
	assign wd_eff = w_got_q ? wdata_q : i_wdata;
	assign ws_eff = w_got_q ? wstrb0_q : i_wstrb[0];
	assign do_write = (wst_q == QNP_ST_IDLE) & (aw_got_q | aw_take) & (w_got_q | w_take);
	assign wsel = qnp_decode(wa_eff);

	// channel handshake and response
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			wst_q <= QNP_ST_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb0_q <= 1'b0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= QNP_RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_q <= i_awaddr;
			end
			if (w_take) begin
				wdata_q <= i_wdata;
				wstrb0_q <= i_wstrb[0];
			end
			unique case (wst_q)
				QNP_ST_IDLE: begin
					// ready stays up only for halves not yet taken
					o_awready <= ~(aw_got_q | aw_take) & ~do_write;
					o_wready <= ~(w_got_q | w_take) & ~do_write;
					aw_got_q <= (aw_got_q | aw_take) & ~do_write;
					w_got_q <= (w_got_q | w_take) & ~do_write;
					if (do_write) begin
						wst_q <= QNP_ST_RESP;
						o_bvalid <= 1'b1;
						o_bresp <= wsel[6] ? QNP_RESP_SLVERR : QNP_RESP_OKAY;
					end
				end
				QNP_ST_RESP: begin
					// hold response until accepted
					if (i_bready) begin
						o_bvalid <= 1'b0;
						o_awready <= 1'b1;
						o_wready <= 1'b1;
						wst_q <= QNP_ST_IDLE;
					end
				end
			endcase
		end
	end

	// register writes
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			dir_q <= QNP_DIR_RESET; // [R06]
			pup_q <= QNP_PUP_RESET; // [R08]
			data_q <= QNP_DATA_RESET; // [R18]
		end else if (do_write & ws_eff) begin
			// data stored whatever the direction
			if (wsel[0]) data_q[3:0] <= wd_eff[3:0]; // [R09]
			if (wsel[1]) data_q[7:4] <= wd_eff[3:0];
			if (wsel[2]) data_q[11:8] <= wd_eff[3:0];
			if (wsel[3]) data_q[15:12] <= wd_eff[3:0];
			if (wsel[4]) dir_q <= wd_eff[3:0]; // [R02]
			if (wsel[5]) pup_q <= wd_eff[3:0]; // [R07]
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	logic ar_take; // read address handshake
	logic [6:0] rsel; // read select
	logic [3:0] rnib; // selected nibble
	logic [15:0] pin_rd; // pin level as read

	assign ar_take = i_arvalid & o_arready;
	assign rsel = qnp_decode(i_araddr);
	// the read shows the pin itself in either mode; a released open-drain
	// pin without pull-up reads what the board holds, which may be anything
	assign pin_rd = i_pin; // [R10] [R11] [R16]
	assign rnib = ({4{rsel[0]}} & pin_rd[3:0]) | ({4{rsel[1]}} & pin_rd[7:4]) |
		({4{rsel[2]}} & pin_rd[11:8]) | ({4{rsel[3]}} & pin_rd[15:12]) |
		({4{rsel[4]}} & dir_q) | ({4{rsel[5]}} & pup_q);

	// read handshake and data
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rst_q <= QNP_ST_IDLE;
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= QNP_RESP_OKAY;
		end else begin
			unique case (rst_q)
				QNP_ST_IDLE: begin
					o_arready <= ~ar_take;
					if (ar_take) begin
						rst_q <= QNP_ST_RESP;
						o_rvalid <= 1'b1;
						o_rdata <= {28'h0000000, rnib};
						o_rresp <= rsel[6] ? QNP_RESP_SLVERR : QNP_RESP_OKAY;
					end
				end
				QNP_ST_RESP: begin
					if (i_rready) begin
						o_rvalid <= 1'b0;
						o_arready <= 1'b1;
						rst_q <= QNP_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// reset leaves every group undriven
	property p_reset_input;
		@(posedge i_ref_clk) ($past(i_reset) && !i_reset) |-> (o_pin_oe == 16'h0000);
	endproperty
	reset_input_a: assert property (p_reset_input) else $error("pins driven after reset"); // [R06]

	// non-dedicated pin undriven while its group direction is zero
	property p_dir_oe;
		@(posedge i_ref_clk) disable iff (i_reset)
		!$past(i_reset) |-> ((o_pin_oe & ~DED_MASK & ~$past(dir_pin)) == 16'h0000);
	endproperty
	dir_oe_a: assert property (p_dir_oe) else $error("input pin driven"); // [R03]

	// complementary pins enabled exactly when in output mode
	property p_out_drive;
		@(posedge i_ref_clk) disable iff (i_reset)
		!$past(i_reset) |-> (((o_pin_oe ^ $past(out_mode)) & ~OD_EFF) == 16'h0000);
	endproperty
	out_drive_a: assert property (p_out_drive) else $error("output pin not driven"); // [R04]

	// driven pin value equals data one cycle earlier
	property p_value;
		@(posedge i_ref_clk) disable iff (i_reset)
		!$past(i_reset) |-> (o_pin == $past(data_q));
	endproperty
	pin_value_a: assert property (p_value) else $error("pin value mismatch"); // [R05]

	// open-drain pin never drives high
	property p_od_low;
		@(posedge i_ref_clk) disable iff (i_reset)
		((o_pin_oe & o_pin & OD_EFF) == 16'h0000);
	endproperty
	od_low_a: assert property (p_od_low) else $error("open drain drove high"); // [R17]

	// dedicated pins never pulled up
	property p_ded_pull;
		@(posedge i_ref_clk) disable iff (i_reset)
		((o_pullup_en & DED_MASK) == 16'h0000);
	endproperty
	ded_pull_a: assert property (p_ded_pull) else $error("dedicated pin pulled"); // [R15]

	// pull-up enable is inverse of group bit
	property p_pull;
		@(posedge i_ref_clk) disable iff (i_reset)
		!$past(i_reset) |-> ((o_pullup_en | DED_MASK) == (~$past(pup_pin) | DED_MASK));
	endproperty
	pullup_map_a: assert property (p_pull) else $error("pull-up mapping wrong"); // [R07]

	// write to the group 0 data register lands next cycle even in input mode
	sequence s_data0_write;
		do_write & ws_eff & wsel[0];
	endsequence
	property p_store;
		@(posedge i_ref_clk) disable iff (i_reset)
		s_data0_write |=> (data_q[3:0] == $past(wd_eff[3:0]));
	endproperty
	data_store_a: assert property (p_store) else $error("data write lost"); // [R09]

	// read of group 1 data register returns pins sampled at address
	sequence s_rd_group1;
		ar_take & rsel[1];
	endsequence
	property p_rd;
		@(posedge i_ref_clk) disable iff (i_reset)
		s_rd_group1 |=> (o_rvalid && o_rdata[3:0] == $past(i_pin[7:4]));
	endproperty
	read_pin_a: assert property (p_rd) else $error("read not pin level"); // [R10]
	// same relation checked when the group drives
	property p_rd_out;
		@(posedge i_ref_clk) disable iff (i_reset)
		(s_rd_group1 and dir_q[1]) |=> (o_rdata[3:0] == $past(i_pin[7:4]));
	endproperty
	read_out_a: assert property (p_rd_out) else $error("output read wrong"); // [R11]

	// direction register reads back what was written
	property p_dir_rb;
		@(posedge i_ref_clk) disable iff (i_reset)
		(ar_take & rsel[4]) |=> (o_rdata == {28'h0000000, $past(dir_q)});
	endproperty
	dir_readback_a: assert property (p_dir_rb) else $error("direction readback wrong"); // [R02]

	// pull-up disable register reads back what was written
	property p_pup_rb;
		@(posedge i_ref_clk) disable iff (i_reset)
		(ar_take & rsel[5]) |=> (o_rdata == {28'h0000000, $past(pup_q)});
	endproperty
	pup_readback_a: assert property (p_pup_rb) else $error("pull-up readback wrong"); // [R07]

	// complementary dedicated pins drive whatever the direction
	property p_ded_drive;
		@(posedge i_ref_clk) disable iff (i_reset)
		!$past(i_reset) |-> ((~o_pin_oe & DED_MASK & ~OD_EFF) == 16'h0000);
	endproperty
	ded_drive_a: assert property (p_ded_drive) else $error("dedicated pin released"); // [R14]

	// write answer follows both halves, error for holes in the map
	property p_wr_resp;
		@(posedge i_ref_clk) disable iff (i_reset)
		do_write |=> (o_bvalid && o_bresp == ($past(wsel[6]) ? QNP_RESP_SLVERR : QNP_RESP_OKAY));
	endproperty
	write_resp_a: assert property (p_wr_resp) else $error("write response wrong"); // [R01]
endmodule
